// ---- src/sazv_pkg.sv ----
package sazv_pkg;
  // ==========================================================
  // register byte offsets (index times four where an index is given)
  localparam logic [7:0] SOCKET_CONTROL_IDX = 8'h10;
  localparam logic [7:0] SYSTEM_CONTROL_IDX = 8'h80;
  localparam logic [7:0] CARD_CONTROL_IDX   = 8'h91;
  localparam logic [9:0] SOCKET_CONTROL_ADDR = 10'h040;
  localparam logic [9:0] SYSTEM_CONTROL_ADDR = 10'h200;
  localparam logic [9:0] CARD_CONTROL_ADDR   = 10'h244;
  localparam logic [9:0] FORCE_EVENT_ADDR    = 10'h300;
  localparam logic [9:0] CARD_STATE_ADDR     = 10'h304;
  localparam logic [9:0] CARD_CONTROL1_ADDR  = 10'h308;
  // ==========================================================
  // field positions
  localparam int VIDEO_ENABLE_BIT   = 9;
  localparam int STD_MODEL_BIT      = 10;
  localparam int VIDEO_ACTIVE_BIT   = 11;
  localparam int OSC_ENABLE_BIT     = 27;
  localparam int PLATFORM_SUPP_BIT  = 27;
  localparam int SPEAKER_EN_BIT     = 1;
  localparam int PWM_ROUTE_BIT      = 2;
  localparam int CARD_TYPE_BIT      = 0;  // 1 = cardbus card
  localparam int IO_MODE_BIT        = 1;  // 16-bit card in i/o mode
  // ==========================================================
  // reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // ring oscillator: nominal 16 kHz derived from 20 MHz pclk
  localparam int OSC_FREQ_HZ  = 16000;
  localparam int PCLK_FREQ_HZ = 20000000;
  localparam int OSC_HALF_CYC = PCLK_FREQ_HZ / (2 * OSC_FREQ_HZ);
endpackage

// ---- src/sazv_socket.sv ----
`timescale 1ns/1ps
// ============================================================
// per-socket audio selection and status terminal bias
module sazv_socket (
  // socket signals
  sazv_socket_if.sock s
);
  // 16-bit card in i/o mode: battery detect 2 acts as speaker input
  assign s.speaker_bit = s.cardbus_card ? s.audio_in
                       : (s.io_mode & s.audio_in);
  // pwm request only from a cardbus function
  assign s.pwm_req     = s.cardbus_card & s.pwm_route;
  assign s.pwm_bit     = s.audio_in;
  // bias the status change terminal by card type
  assign s.pullup_en   = ~s.cardbus_card;
  assign s.pulldown_en = s.cardbus_card;
endmodule

// ---- src/sazv_socket_if.sv ----
`timescale 1ns/1ps
// per-socket control and audio signals between top and socket logic
interface sazv_socket_if;
  logic video_enable;    // socket video enable bit
  logic platform_supp;   // platform video support bit
  logic cardbus_card;    // inserted card is cardbus
  logic io_mode;         // 16-bit card configured for i/o
  logic pwm_route;       // pwm audio route enable
  logic audio_in;        // raw audio terminal level
  logic speaker_bit;     // binary audio contribution
  logic pwm_bit;         // pwm audio contribution
  logic pwm_req;         // socket requests pwm routing
  logic pullup_en;       // status change pullup
  logic pulldown_en;     // status change pulldown
  modport top (output video_enable, platform_supp, cardbus_card, io_mode,
               pwm_route, audio_in,
               input speaker_bit, pwm_bit, pwm_req, pullup_en,
               pulldown_en);
  modport sock (input video_enable, platform_supp, cardbus_card, io_mode,
                pwm_route, audio_in,
                output speaker_bit, pwm_bit, pwm_req, pullup_en,
                pulldown_en);
endinterface

// ---- src/sazv_top.sv ----
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module sazv_top #(
  parameter int NUM_SOCK = 2    // socket count
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // socket terminals
  input  wire logic [1:0]  battery_detect_2,
  input  wire logic [1:0]  card_is_cardbus,
  input  wire logic [1:0]  card_io_mode,
  output logic      [1:0]  status_change_pullup,
  output logic      [1:0]  status_change_pulldown,
  // audio and clock outputs
  output logic             speaker_out,
  output logic             pwm_audio_out,
  output logic             internal_osc_clk
);
  // ==========================================================
  // state record
  typedef struct packed {
    logic [1:0]  video_enable;    // per socket enable
    logic [1:0]  platform_supp;   // per socket platform support
    logic        osc_enable;      // internal oscillator enable
    logic [1:0]  speaker_en;      // per function speaker enable
    logic [1:0]  pwm_route;       // per function pwm route
    logic [9:0]  osc_cnt;         // oscillator half period count
    logic        osc_clk;         // oscillator output
    logic        speaker;         // speaker output
    logic        pwm;             // pwm output
    logic [1:0]  pu;              // pullup enables
    logic [1:0]  pd;              // pulldown enables
    logic [31:0] rdata;           // read data
    logic        ready;           // apb ready
    logic        err;             // apb error
  } sazv_state_s;

  sazv_state_s st_reg;            // registered state
  sazv_state_s st_next;           // next state

  // ==========================================================
  // socket instances
  sazv_socket_if sif [NUM_SOCK] ();
  logic [1:0] spk_bits;           // binary audio per socket
  logic [1:0] pwm_bits;           // pwm audio per socket
  logic [1:0] pwm_reqs;           // pwm requests per socket
  logic [1:0] pu_w;               // pullups from sockets
  logic [1:0] pd_w;               // pulldowns from sockets

  for (genvar i = 0; i < NUM_SOCK; i++) begin : g_sock
    assign sif[i].video_enable  = st_reg.video_enable[i];
    assign sif[i].platform_supp = st_reg.platform_supp[i];
    assign sif[i].cardbus_card  = card_is_cardbus[i];
    assign sif[i].io_mode       = card_io_mode[i];
    assign sif[i].pwm_route     = st_reg.pwm_route[i];
    assign sif[i].audio_in      = battery_detect_2[i];
    assign spk_bits[i]          = sif[i].speaker_bit;
    assign pwm_bits[i]          = sif[i].pwm_bit;
    assign pwm_reqs[i]          = sif[i].pwm_req;
    assign pu_w[i]              = sif[i].pullup_en;
    assign pd_w[i]              = sif[i].pulldown_en;
    sazv_socket u_sock (
      .s (sif[i])
    );
  end

  // ==========================================================
  // apb decode helpers
  logic       setup_ph;           // setup phase of a transfer
  logic [9:0] word_addr;          // byte address inside the map
  logic       aligned;            // whole word, upper bits zero
  logic       active;             // video active indicator
  assign setup_ph  = psel & ~penable;
  // decode on the byte address; the top bits must be clear
  assign word_addr = paddr[9:0];
  assign aligned   = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign active    = |st_reg.video_enable;

  // ==========================================================
  // next-state logic
  always_comb begin
    st_next       = st_reg;
    st_next.ready = 1'b0;
    st_next.err   = 1'b0;
    // register access taken in setup, answered next cycle
    if (setup_ph) begin
      st_next.ready = 1'b1;
      st_next.rdata = sazv_pkg::RESET_WORD;
      if (!aligned) begin
        st_next.err = 1'b1;
      end else begin
        unique case (word_addr)
          sazv_pkg::SOCKET_CONTROL_ADDR: begin
            if (pwrite) begin
              st_next.video_enable[0] =
                pwdata[sazv_pkg::VIDEO_ENABLE_BIT];
            end else begin
              st_next.rdata[sazv_pkg::VIDEO_ENABLE_BIT] =
                st_reg.video_enable[0];
              st_next.rdata[sazv_pkg::STD_MODEL_BIT] = 1'b1;
              st_next.rdata[sazv_pkg::VIDEO_ACTIVE_BIT] = active;
            end
          end
          sazv_pkg::SYSTEM_CONTROL_ADDR: begin
            if (pwrite) begin
              st_next.osc_enable =
                pwdata[sazv_pkg::OSC_ENABLE_BIT];
            end else begin
              st_next.rdata[sazv_pkg::OSC_ENABLE_BIT] = st_reg.osc_enable;
            end
          end
          sazv_pkg::CARD_CONTROL_ADDR,
          sazv_pkg::CARD_CONTROL1_ADDR: begin
            // second function's card control at its own word
            if (pwrite) begin
              if (word_addr == sazv_pkg::CARD_CONTROL_ADDR) begin
                st_next.speaker_en[0] = pwdata[sazv_pkg::SPEAKER_EN_BIT];
                st_next.pwm_route[0]  = pwdata[sazv_pkg::PWM_ROUTE_BIT];
              end else begin
                st_next.speaker_en[1] = pwdata[sazv_pkg::SPEAKER_EN_BIT];
                st_next.pwm_route[1]  = pwdata[sazv_pkg::PWM_ROUTE_BIT];
              end
            end else if (word_addr == sazv_pkg::CARD_CONTROL_ADDR) begin
              st_next.rdata[sazv_pkg::SPEAKER_EN_BIT] =
                st_reg.speaker_en[0];
              st_next.rdata[sazv_pkg::PWM_ROUTE_BIT] = st_reg.pwm_route[0];
            end else begin
              st_next.rdata[sazv_pkg::SPEAKER_EN_BIT] =
                st_reg.speaker_en[1];
              st_next.rdata[sazv_pkg::PWM_ROUTE_BIT] = st_reg.pwm_route[1];
            end
          end
          sazv_pkg::FORCE_EVENT_ADDR: begin
            // writes of one set support; only path to set it
            if (pwrite) begin
              st_next.platform_supp[0] = st_reg.platform_supp[0] |
                pwdata[sazv_pkg::PLATFORM_SUPP_BIT];
              st_next.platform_supp[1] = st_reg.platform_supp[1] |
                pwdata[sazv_pkg::PLATFORM_SUPP_BIT + 1];
            end
          end
          sazv_pkg::CARD_STATE_ADDR: begin
            // present state: read-only support bits
            if (pwrite) begin
              st_next.err = 1'b1;
            end else begin
              st_next.rdata[sazv_pkg::PLATFORM_SUPP_BIT] =
                st_reg.platform_supp[0];
              st_next.rdata[sazv_pkg::PLATFORM_SUPP_BIT + 1] =
                st_reg.platform_supp[1];
              st_next.rdata[1:0] = st_reg.video_enable;
            end
          end
          default: begin
            st_next.err = 1'b1;   // unmapped address
          end
        endcase
      end
    end
    // ring oscillator, stopped and low while disabled
    if (st_reg.osc_enable) begin
      if (st_reg.osc_cnt == 10'(sazv_pkg::OSC_HALF_CYC - 1)) begin
        st_next.osc_cnt = 10'h000;
        st_next.osc_clk = ~st_reg.osc_clk;
      end else begin
        st_next.osc_cnt = st_reg.osc_cnt + 10'h001;
      end
    end else begin
      st_next.osc_cnt = 10'h000;
      st_next.osc_clk = 1'b0;
    end
    // speaker: xor of sockets, low while disabled
    st_next.speaker = (st_reg.speaker_en[0] | st_reg.speaker_en[1]) &
                      (spk_bits[0] ^ spk_bits[1]);
    // pwm: socket 0 first
    if (pwm_reqs[0]) begin
      st_next.pwm = pwm_bits[0];
    end else if (pwm_reqs[1]) begin
      st_next.pwm = pwm_bits[1];
    end else begin
      st_next.pwm = 1'b0;
    end
    st_next.pu = pu_w;
    st_next.pd = pd_w;
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs from flip-flops
  assign prdata                 = st_reg.rdata;
  assign pready                 = st_reg.ready;
  assign pslverr                = st_reg.err;
  assign speaker_out            = st_reg.speaker;
  assign pwm_audio_out          = st_reg.pwm;
  assign internal_osc_clk       = st_reg.osc_clk;
  assign status_change_pullup   = st_reg.pu;
  assign status_change_pulldown = st_reg.pd;
endmodule

// ---- verification/sazv_card_model.sv ----
`timescale 1ns/1ps
// ============================================
// two inserted cards: type, mode and audio level
module sazv_card_model (
  // clock
  input  wire logic       pclk,
  // card choice from the bench
  input  wire logic [1:0] kind_c, io_c, aud_c,
  // socket terminals
  output logic      [1:0] battery_detect_2,
  output logic      [1:0] card_is_cardbus,
  output logic      [1:0] card_io_mode
);
  // quiet 16-bit cards at power up
  initial {battery_detect_2, card_is_cardbus, card_io_mode} = '0;
  // cards change state just after an edge
  always @(posedge pclk) begin
    card_is_cardbus  <= kind_c;
    card_io_mode     <= io_c;
    battery_detect_2 <= aud_c;
  end
endmodule

// ---- verification/sazv_chk.sv ----
`timescale 1ns/1ps
// ============================================
// port watch for the socket support block
module sazv_chk (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb slave side
  input wire logic        psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic        pready, pslverr,
  // socket terminals
  input wire logic [1:0]  battery_detect_2, card_is_cardbus,
  input wire logic [1:0]  card_io_mode,
  input wire logic [1:0]  status_change_pullup, status_change_pulldown,
  // audio and clock outputs
  input wire logic        speaker_out, pwm_audio_out, internal_osc_clk
);
  logic [9:0] cnt;    // steady cycles of the slow clock
  logic       osc_q;  // slow clock one edge ago
  wire  [1:0] aud = battery_detect_2 & (card_is_cardbus | card_io_mode);
  // count cycles between slow clock changes, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt   <= '0;
      osc_q <= 1'b0;
    end else begin
      osc_q <= internal_osc_clk;
      cnt   <= (internal_osc_clk != osc_q) ? '0 : cnt + {9'h0, ~&cnt};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (psel && !penable && paddr == 12'h00C
    |=> pslverr && pready) else $error("unmapped access not refused");
  a_pullup_card: assert property ($past(presetn) |->
    status_change_pullup == ~$past(card_is_cardbus))
    else $error("pullup does not follow card type");
  a_pulldown_card: assert property ($past(presetn) |->
    status_change_pulldown == $past(card_is_cardbus))
    else $error("pulldown does not follow card type");
  a_speaker_xor: assert property (speaker_out |->
    $past(aud[0] ^ aud[1])) else $error("speaker high without audio");
  a_pwm_source: assert property (pwm_audio_out |->
    $past(|(battery_detect_2 & card_is_cardbus)))
    else $error("pwm high without cardbus audio");
  a_osc_period: assert property (internal_osc_clk && !osc_q |->
    cnt >= 10'(sazv_pkg::OSC_HALF_CYC - 1))
    else $error("slow clock runs too fast");
  a_osc_reset: assert property (!$past(presetn) |->
    !internal_osc_clk) else $error("slow clock active out of reset");
endmodule

// ---- verification/socket_audio_zv_misc_tb.sv ----
`timescale 1ns/1ps
bind sazv_top sazv_chk chk_u (.*);
module socket_audio_zv_misc_tb;
  // ============================================
  // nets
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, ps;
  logic        speaker_out, pwm_audio_out, internal_osc_clk, er;
  logic [1:0]  battery_detect_2, card_is_cardbus, card_io_mode;
  logic [1:0]  status_change_pullup, status_change_pulldown;
  logic [1:0]  kind_c, io_c, aud_c;
  logic [9:0]  v;        // {route, spk en, audio, io, kind}
  int          errors, n_checks, n;
  sazv_top dut_u (.*);
  sazv_card_model card_u (.*);
  // 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // one comparison
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  // counts, verdict, stop
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one apb transfer: setup, then access until pready at an edge
  task automatic apb(input logic w, input logic [9:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite} <= {2'b10, w};
    paddr  <= {2'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // software actions: 0 enable, 1 busy, 2 no support, 3 move card
  function automatic logic [1:0] zv_action(input logic [31:0] sc, st);
    if (st[27]) zv_action = sc[11] ? 2'h1 : 2'h0;
    else zv_action = st[28] ? 2'h3 : 2'h2;
  endfunction
  // software enable procedure for socket 0, then read back
  task automatic zv_try(input logic [1:0] want);
    logic [1:0] act;
    logic       on;
    on = ~want[1];
    apb(0, sazv_pkg::CARD_STATE_ADDR, '0);
    ps = rd;
    apb(0, sazv_pkg::SOCKET_CONTROL_ADDR, '0);
    act = zv_action(rd, ps);
    chk("zv_action", act, want);
    // write the enable only when the model bit is set and the action is 0
    if (rd[10] === 1'b1 && act == 2'h0) begin
      apb(1, sazv_pkg::SOCKET_CONTROL_ADDR, 32'h0000_0200);
    end
    apb(0, sazv_pkg::SOCKET_CONTROL_ADDR, '0);
    chk("zv_enable", rd[11:9], {on, 1'b1, on});
  endtask
  // expected {speaker, pwm}
  function automatic logic [1:0] exp_out(input logic [9:0] c);
    logic [1:0] s;
    s = c[5:4] & (c[1:0] | c[3:2]);
    exp_out[1] = |c[7:6] & (s[0] ^ s[1]);
    exp_out[0] = (c[0] & c[8]) ? c[4] : c[1] & c[9] & c[5];
  endfunction
  // hang guard
  initial begin
    #500000;
    errors++;
    print_verdict();
  end
  // ============================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, kind_c, io_c, aud_c} = '0;
    {paddr, pwdata, errors, n_checks} = '0;
    void'($urandom(32'h81C05B92));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, sazv_pkg::SYSTEM_CONTROL_ADDR, '0);
    chk("osc_en", {rd[27], internal_osc_clk}, 0);
    apb(0, sazv_pkg::SOCKET_CONTROL_ADDR, '0);
    chk("sock_ctl", rd[11:9], 3'b010);
    apb(0, 10'h00C, '0);
    chk("unmapped", er, 1);
    apb(0, 10'h041, '0);
    chk("misalign", er, 1);
    apb(1, sazv_pkg::CARD_STATE_ADDR, '1);
    chk("ro_write", er, 1);
    apb(0, sazv_pkg::CARD_STATE_ADDR, '0);
    chk("supp_idle", rd[28:27], 0);
    // no socket supported, then only the other one
    zv_try(2'h2);
    apb(1, sazv_pkg::FORCE_EVENT_ADDR, 32'h1000_0000);
    zv_try(2'h3);
    apb(1, sazv_pkg::FORCE_EVENT_ADDR, 32'h0800_0000);
    apb(0, sazv_pkg::CARD_STATE_ADDR, '0);
    chk("supp_set", rd[28:27], 3);
    // supported and idle: enable; then busy: leave alone
    zv_try(2'h0);
    chk("vid_on", rd[11:9], 3'b111);
    zv_try(2'h1);
    apb(1, sazv_pkg::SOCKET_CONTROL_ADDR, '0);
    apb(0, sazv_pkg::SOCKET_CONTROL_ADDR, '0);
    chk("vid_off", rd[11], 0);
    apb(1, sazv_pkg::SYSTEM_CONTROL_ADDR, 32'h0800_0000);
    n = 0;
    while (internal_osc_clk !== 1'b1 && n < 2000) begin
      @(negedge pclk);
      n++;
    end
    n = 0;
    while (internal_osc_clk === 1'b1 && n < 2000) begin
      @(negedge pclk);
      n++;
    end
    chk("osc_half", n, sazv_pkg::OSC_HALF_CYC);
    // reset in mid-run: oscillator and support bits drop
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("osc_rst", internal_osc_clk, 0);
    presetn <= 1'b1;
    apb(0, sazv_pkg::SYSTEM_CONTROL_ADDR, '0);
    chk("osc_off", {rd[27], internal_osc_clk}, 0);
    apb(0, sazv_pkg::CARD_STATE_ADDR, '0);
    chk("supp_rst", rd[28:27], 0);
    // corner cases first, then random cards and settings
    for (int i = 0; i < 24; i++) begin
      v = (i == 0) ? 10'h3D3 : (i == 1) ? 10'h313 : 10'($urandom);
      apb(1, sazv_pkg::CARD_CONTROL_ADDR, {29'h0, v[8], v[6], 1'b0});
      apb(1, sazv_pkg::CARD_CONTROL1_ADDR, {29'h0, v[9], v[7], 1'b0});
      apb(0, sazv_pkg::CARD_CONTROL_ADDR, '0);
      chk("cc_fn0", rd[2:1], {v[8], v[6]});
      apb(0, sazv_pkg::CARD_CONTROL1_ADDR, '0);
      chk("cc_fn1", rd[2:1], {v[9], v[7]});
      @(posedge pclk);
      {aud_c, io_c, kind_c} <= v[5:0];
      repeat (3) @(negedge pclk);
      chk("spk_pwm", {speaker_out, pwm_audio_out},
          exp_out(v));
      chk("bias", {status_change_pullup, status_change_pulldown},
          {~v[1:0], v[1:0]});
    end
    print_verdict();
  end
endmodule
